/* lop_defs.svh */
// Constants for the link OAM port control block.
`ifndef LOP_DEFS_SVH
`define LOP_DEFS_SVH
`define LOP_MTU_RESET 16'h05DC
`define LOP_REV_RESET 16'h0000
// The default vendor identifier is arbitrary, not an assigned one.
`define LOP_OUI_RESET 24'h123456
`define LOP_FIFO_DEPTH 8
`define LOP_CODE_INFO 8'h00
`define LOP_CODE_EVENT 8'h01
`define LOP_CODE_VARREQ 8'h02
`define LOP_CODE_VARRSP 8'h03
`define LOP_CODE_LOOPBACK 8'h04
`endif

/* lop_pkg.sv */
// Types for the link OAM port control block.
package lop_pkg;
    typedef enum logic [5:0] {
        DISC_FAULT = 6'h01,
        DISC_ACTIVE = 6'h02,
        DISC_PASSIVE = 6'h04,
        DISC_SLR = 6'h08,
        DISC_SLR_OK = 6'h10,
        DISC_ANY = 6'h20
    } lop_disc_type;
    typedef enum logic [1:0] {
        PERM_FAULT = 2'h0,
        PERM_RX = 2'h1,
        PERM_INFO = 2'h2,
        PERM_ANY = 2'h3
    } lop_perm_type;
    typedef enum logic [1:0] {
        PAR_FWD = 2'h0,
        PAR_LB = 2'h1,
        PAR_DISC = 2'h2
    } lop_par_type;
    typedef struct packed {
        logic active_mode;
        logic unidir;
        logic loopback_cap;
        logic linkmon_cap;
        logic mib_cap;
        logic [15:0] max_pdu;
        logic [23:0] oui;
        logic [15:0] revision;
    } lop_info_type;
endpackage

/* lop_port.sv */
// Link OAM port control: discovery, multiplexer, parser and frame FIFO.
`timescale 1ns/1ps
`include "lop_defs.svh"

////////////////////////////////////////////////////////////////////////////////
module lop_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic sys_rst,
    // Fill side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem[rd_q];
    always_ff @(posedge core_clk)
    begin
        if (push)
        begin
            mem[wr_q] <= in_data;
        end
    end
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            if (pop)
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
module lop_port #(
    parameter int WIDTH = 8,
    parameter int DEPTH = `LOP_FIFO_DEPTH,
    parameter logic [23:0] VENDOR_OUI = `LOP_OUI_RESET
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic sys_rst,
    // Configuration.
    input wire logic cfg_active,
    input wire logic cfg_loopback_cap,
    input wire logic cfg_linkmon_cap,
    input wire logic cfg_mib_cap,
    input wire logic [15:0] cfg_max_pdu,
    input wire logic lb_request,
    // Pins from the PHY and link.
    input wire logic phy_unidir,
    input wire logic link_ok,
    // Peer information received.
    input wire logic peer_info_valid,
    input wire lop_pkg::lop_info_type peer_info,
    input wire logic peer_sat,
    input wire logic peer_event_valid,
    input wire logic var_req_valid,
    // Transmit request check.
    input wire logic [7:0] tx_code,
    output logic tx_allowed,
    // Client to lower sublayer.
    input wire logic cli_valid,
    output logic cli_ready,
    input wire logic [WIDTH-1:0] cli_data,
    output logic low_valid,
    input wire logic low_ready,
    output logic [WIDTH-1:0] low_data,
    // Received frames.
    input wire logic rx_valid,
    output logic rx_ready,
    input wire logic [WIDTH-1:0] rx_data,
    output logic up_valid,
    input wire logic up_ready,
    output logic [WIDTH-1:0] up_data,
    // Status.
    output lop_pkg::lop_disc_type disc_state,
    output lop_pkg::lop_perm_type perm,
    output logic mux_fwd,
    output lop_pkg::lop_par_type par_state,
    output lop_pkg::lop_info_type local_info,
    output lop_pkg::lop_info_type peer_status,
    output logic [15:0] eff_pdu,
    output logic peer_parse,
    output logic event_accept,
    output logic var_rsp_send
);
    lop_pkg::lop_disc_type disc_q;
    lop_pkg::lop_disc_type disc_d;
    lop_pkg::lop_par_type par_q;
    lop_pkg::lop_info_type peer_q;
    lop_pkg::lop_info_type cfg_prev_q;
    logic [15:0] rev_q;
    logic [15:0] eff_q;
    logic lb_q;
    logic parse_q;
    logic evt_q;
    logic rsp_q;
    logic [1:0] unidir_sync_q;
    logic [1:0] link_sync_q;
    lop_pkg::lop_info_type cfg_now;
    logic fifo_v;
    logic fifo_r;
    logic [WIDTH-1:0] fifo_d;

    // Pin inputs pass two flops before use.
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            unidir_sync_q <= '0;
            link_sync_q <= '0;
        end
        else
        begin
            unidir_sync_q <= {unidir_sync_q[0], phy_unidir};
            link_sync_q <= {link_sync_q[0], link_ok};
        end
    end
    wire unidir = unidir_sync_q[1];
    wire link_up = link_sync_q[1];

    ////////////////////////////////////////////////////////////////////////////
    // Local information; unidir has no configuration input at all.
    assign cfg_now = '{active_mode: cfg_active, unidir: unidir,
                       loopback_cap: cfg_loopback_cap, linkmon_cap: cfg_linkmon_cap,
                       mib_cap: cfg_mib_cap, max_pdu: cfg_max_pdu,
                       oui: VENDOR_OUI, revision: 16'h0000};
    wire cfg_changed = (cfg_now != cfg_prev_q);
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            rev_q <= `LOP_REV_RESET;
            cfg_prev_q <= cfg_now;
        end
        else
        begin
            cfg_prev_q <= cfg_now;
            if (cfg_changed)
                rev_q <= rev_q + 16'h0001;
        end
    end
    always_comb
    begin
        local_info = cfg_now;
        local_info.revision = rev_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Discovery machine.
    wire remote_ok = peer_info_valid && peer_sat;
    always_comb
    begin
        disc_d = disc_q;
        unique case (disc_q)
            lop_pkg::DISC_FAULT:
                if (link_up && !unidir)
                    disc_d = cfg_active ? lop_pkg::DISC_ACTIVE : lop_pkg::DISC_PASSIVE;
            lop_pkg::DISC_ACTIVE, lop_pkg::DISC_PASSIVE:
                if (peer_info_valid)
                    disc_d = lop_pkg::DISC_SLR;
            lop_pkg::DISC_SLR:
                if (remote_ok)
                    disc_d = lop_pkg::DISC_SLR_OK;
            lop_pkg::DISC_SLR_OK:
                if (peer_info_valid && peer_q.revision != 16'h0000 || remote_ok)
                    disc_d = lop_pkg::DISC_ANY;
            lop_pkg::DISC_ANY:
                if (peer_info_valid && !peer_sat)
                    disc_d = lop_pkg::DISC_SLR;
            default:
                disc_d = lop_pkg::DISC_FAULT;
        endcase
        if (!link_up)
            disc_d = lop_pkg::DISC_FAULT;
    end
    assign disc_state = disc_q;

    // Permission follows the discovery state and governs the local entity only.
    assign perm = (disc_q == lop_pkg::DISC_FAULT) ? lop_pkg::PERM_FAULT :
                  (disc_q == lop_pkg::DISC_PASSIVE) ? lop_pkg::PERM_RX :
                  (disc_q == lop_pkg::DISC_ANY) ? lop_pkg::PERM_ANY : lop_pkg::PERM_INFO;

    function automatic logic code_ok(lop_pkg::lop_perm_type p, logic [7:0] c);
        unique case (p)
            lop_pkg::PERM_FAULT: code_ok = (c == `LOP_CODE_INFO);
            lop_pkg::PERM_RX: code_ok = 1'b0;
            lop_pkg::PERM_INFO: code_ok = (c == `LOP_CODE_INFO);
            lop_pkg::PERM_ANY: code_ok = 1'b1;
        endcase
    endfunction
    assign tx_allowed = code_ok(perm, tx_code) &&
                        (tx_code != `LOP_CODE_VARRSP || cfg_mib_cap);

    ////////////////////////////////////////////////////////////////////////////
    // Peer record, size negotiation, loopback and capability gates.
    wire [15:0] min_pdu = (peer_q.max_pdu < cfg_max_pdu) ? peer_q.max_pdu : cfg_max_pdu;
    wire any_state = (disc_q == lop_pkg::DISC_ANY);
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            disc_q <= lop_pkg::DISC_FAULT;
            peer_q <= '0;
            eff_q <= `LOP_MTU_RESET;
            lb_q <= 1'b0;
            parse_q <= 1'b0;
            evt_q <= 1'b0;
            rsp_q <= 1'b0;
        end
        else
        begin
            disc_q <= disc_d;
            parse_q <= peer_info_valid && (peer_info != peer_q);
            if (peer_info_valid && peer_info != peer_q)
                peer_q <= peer_info;
            eff_q <= (peer_q.max_pdu == 16'h0000) ? cfg_max_pdu : min_pdu;
            if (!any_state || !cfg_loopback_cap)
                lb_q <= 1'b0;
            else if (lb_request)
                lb_q <= 1'b1;
            evt_q <= peer_event_valid && cfg_linkmon_cap;
            rsp_q <= var_req_valid && cfg_mib_cap && any_state;
        end
    end
    assign peer_status = peer_q;
    assign eff_pdu = eff_q;
    assign peer_parse = parse_q;
    assign event_accept = evt_q;
    assign var_rsp_send = rsp_q;

    // Mux forwards only when any traffic is permitted and not looping.
    assign mux_fwd = any_state && !lb_q;
    assign par_state = lb_q ? lop_pkg::PAR_LB : (any_state ? lop_pkg::PAR_FWD : lop_pkg::PAR_DISC);

    ////////////////////////////////////////////////////////////////////////////
    // Transmit path: client frames buffered, then forwarded or dropped.
    // Loopback has priority on the lower sublayer; looped frames still stall while low_ready is low.
    wire par_fwd = (par_q == lop_pkg::PAR_FWD);
    wire par_lb = (par_q == lop_pkg::PAR_LB);
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            par_q <= lop_pkg::PAR_DISC;
        else
            par_q <= par_state;
    end
    lop_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .in_valid(cli_valid),
        .in_ready(cli_ready),
        .in_data(cli_data),
        .out_valid(fifo_v),
        .out_ready(fifo_r),
        .out_data(fifo_d)
    );
    assign fifo_r = mux_fwd ? (low_ready && !par_lb) : 1'b1;
    assign low_valid = par_lb ? rx_valid : (mux_fwd && fifo_v);
    assign low_data = par_lb ? rx_data : fifo_d;
    assign up_valid = par_fwd && rx_valid;
    assign up_data = rx_data;
    assign rx_ready = par_fwd ? up_ready : (par_lb ? low_ready : 1'b1);

    ////////////////////////////////////////////////////////////////////////////
    // Assertions.
    property p_mux_drop;
        @(posedge core_clk) disable iff (sys_rst) (!mux_fwd && !par_lb) |-> !low_valid;
    endproperty
    a_mux_drop: assert property (p_mux_drop) else $error("discarding mux sent a frame");
    property p_mux_fwd;
        @(posedge core_clk) disable iff (sys_rst) (mux_fwd && !par_lb && fifo_v) |-> low_valid && low_data == fifo_d;
    endproperty
    a_mux_fwd: assert property (p_mux_fwd) else $error("forwarding mux held a frame");
    property p_par_up;
        @(posedge core_clk) disable iff (sys_rst) up_valid |-> par_fwd && rx_valid;
    endproperty
    a_par_up: assert property (p_par_up) else $error("frame went up outside forwarding");
    property p_par_lb;
        @(posedge core_clk) disable iff (sys_rst) (par_lb && rx_valid) |-> low_valid && low_data == rx_data && !up_valid;
    endproperty
    a_par_lb: assert property (p_par_lb) else $error("loopback frame not returned");
    property p_par_disc;
        @(posedge core_clk) disable iff (sys_rst) (par_q == lop_pkg::PAR_DISC) |-> rx_ready && !up_valid;
    endproperty
    a_par_disc: assert property (p_par_disc) else $error("discarding parser kept a frame");
    property p_eff;
        @(posedge core_clk) disable iff (sys_rst) (peer_q.max_pdu != 16'h0000 && $stable(peer_q) && $stable(cfg_max_pdu))
            |=> eff_pdu <= $past(cfg_max_pdu) && eff_pdu <= $past(peer_q.max_pdu);
    endproperty
    a_eff: assert property (p_eff) else $error("effective size exceeds a limit");
    property p_rev;
        @(posedge core_clk) disable iff (sys_rst) cfg_changed |=> rev_q == $past(rev_q) + 16'h0001;
    endproperty
    a_rev: assert property (p_rev) else $error("revision did not advance");
    property p_fault;
        @(posedge core_clk) disable iff (sys_rst) !link_up |=> disc_state == lop_pkg::DISC_FAULT;
    endproperty
    a_fault: assert property (p_fault) else $error("discovery left fault without link");
    sequence s_unidir_fault;
        disc_q == lop_pkg::DISC_FAULT && unidir;
    endsequence
    property p_unidir_hold;
        @(posedge core_clk) disable iff (sys_rst) s_unidir_fault |=> disc_q == lop_pkg::DISC_FAULT;
    endproperty
    a_unidir_hold: assert property (p_unidir_hold) else $error("discovery left fault while unidirectional");
    property p_perm;
        @(posedge core_clk) disable iff (sys_rst) (perm != lop_pkg::PERM_ANY) |-> mux_fwd == 1'b0;
    endproperty
    a_perm: assert property (p_perm) else $error("mux forwarding below full permission");
    property p_tx;
        @(posedge core_clk) disable iff (sys_rst) (perm == lop_pkg::PERM_RX) |-> !tx_allowed;
    endproperty
    a_tx: assert property (p_tx) else $error("transmit allowed in receive only");
    property p_rsp;
        @(posedge core_clk) disable iff (sys_rst) var_rsp_send |-> $past(cfg_mib_cap) && $past(var_req_valid);
    endproperty
    a_rsp: assert property (p_rsp) else $error("variable response without capability");
    property p_evt;
        @(posedge core_clk) disable iff (sys_rst) (peer_event_valid && !cfg_linkmon_cap) |=> !event_accept;
    endproperty
    a_evt: assert property (p_evt) else $error("event taken without link monitoring");
endmodule

/* lop_peer_model.sv */
// Peer link OAM entity and lower sublayer sink.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module lop_peer_model (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic sys_rst,
    // Peer information.
    output logic peer_info_valid,
    output lop_pkg::lop_info_type peer_info,
    output logic peer_sat,
    output logic peer_event_valid,
    output logic var_req_valid,
    // Frames sent to the port.
    output logic rx_valid,
    input wire logic rx_ready,
    output logic [7:0] rx_data,
    // Lower sublayer sink.
    input wire logic low_valid,
    output logic low_ready,
    input wire logic [7:0] low_data,
    input wire logic stall
);
    logic [7:0] got[$];
    logic rdy_n;
    initial
    begin
        {peer_info_valid, peer_sat, peer_event_valid, var_req_valid, rx_valid} = 5'h00;
        peer_info = '0;
        rx_data = 8'h00;
        low_ready = 1'b1;
        rdy_n = 1'b0;
    end
    // A stalled sink models a slow lower sublayer.
    always @(posedge core_clk)
        low_ready <= !stall;
    // Values at the falling edge equal those sampled at the next rising edge.
    always @(negedge core_clk)
    begin
        rdy_n <= rx_ready;
        if (!sys_rst && low_valid === 1'b1 && low_ready)
            got.push_back(low_data);
    end
    task automatic send_info(input lop_pkg::lop_info_type i, input logic s);
        @(posedge core_clk);
        peer_info_valid <= 1'b1;
        peer_info <= i;
        peer_sat <= s;
        @(posedge core_clk);
        peer_info_valid <= 1'b0;
        peer_info <= ~i;
        peer_sat <= ~s;
    endtask
    task automatic pulse(input logic ev);
        @(posedge core_clk);
        peer_event_valid <= ev;
        var_req_valid <= !ev;
        @(posedge core_clk);
        peer_event_valid <= 1'b0;
        var_req_valid <= 1'b0;
    endtask
    task automatic send_rx(input int n, input logic [7:0] base, output logic ok);
        int k;
        int t;
        k = 0;
        t = 0;
        @(posedge core_clk);
        while (k < n && t < 100)
        begin
            rx_valid <= 1'b1;
            rx_data <= base + k[7:0];
            @(posedge core_clk);
            t++;
            if (rdy_n === 1'b1)
                k++;
        end
        rx_valid <= 1'b0;
        rx_data <= ~rx_data;
        ok = (k == n);
    endtask
endmodule

/* test_link_oam_port_control.sv */
// Self-checking testbench for the link OAM port control block.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module test_link_oam_port_control;
    // Arbitrary identifier values.
    localparam logic [23:0] OUI = 24'h5A3C96;
    localparam logic [23:0] PEER_OUI = 24'hC3A511;
    logic core_clk, sys_rst, cfg_active, cfg_loopback_cap, cfg_linkmon_cap, cfg_mib_cap, lb_request;
    logic phy_unidir, link_ok, peer_info_valid, peer_sat, peer_event_valid, var_req_valid, tx_allowed;
    logic cli_valid, cli_ready, low_valid, low_ready, rx_valid, rx_ready, up_valid, up_ready, stall;
    logic mux_fwd, peer_parse, event_accept, var_rsp_send, cli_rdy_n;
    logic [7:0] tx_code, cli_data, low_data, rx_data, up_data;
    logic [7:0] up_got[$];
    logic [15:0] cfg_max_pdu, eff_pdu, rv;
    lop_pkg::lop_info_type peer_info, local_info, peer_status;
    lop_pkg::lop_disc_type disc_state;
    lop_pkg::lop_perm_type perm;
    lop_pkg::lop_par_type par_state;
    int errors, tests_run, n_parse, n_event, n_var, pk, pe, pv;

    lop_port #(.VENDOR_OUI(OUI)) DUT (.core_clk(core_clk), .sys_rst(sys_rst), .cfg_active(cfg_active),
        .cfg_loopback_cap(cfg_loopback_cap), .cfg_linkmon_cap(cfg_linkmon_cap), .cfg_mib_cap(cfg_mib_cap),
        .cfg_max_pdu(cfg_max_pdu), .lb_request(lb_request), .phy_unidir(phy_unidir), .link_ok(link_ok),
        .peer_info_valid(peer_info_valid), .peer_info(peer_info), .peer_sat(peer_sat),
        .peer_event_valid(peer_event_valid), .var_req_valid(var_req_valid), .tx_code(tx_code),
        .tx_allowed(tx_allowed), .cli_valid(cli_valid), .cli_ready(cli_ready), .cli_data(cli_data),
        .low_valid(low_valid), .low_ready(low_ready), .low_data(low_data), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_data(rx_data), .up_valid(up_valid), .up_ready(up_ready), .up_data(up_data),
        .disc_state(disc_state), .perm(perm), .mux_fwd(mux_fwd), .par_state(par_state),
        .local_info(local_info), .peer_status(peer_status), .eff_pdu(eff_pdu), .peer_parse(peer_parse),
        .event_accept(event_accept), .var_rsp_send(var_rsp_send));
    lop_peer_model peer (.core_clk(core_clk), .sys_rst(sys_rst), .peer_info_valid(peer_info_valid),
        .peer_info(peer_info), .peer_sat(peer_sat), .peer_event_valid(peer_event_valid),
        .var_req_valid(var_req_valid), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
        .low_valid(low_valid), .low_ready(low_ready), .low_data(low_data), .stall(stall));

    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    always @(negedge core_clk)
    begin
        cli_rdy_n <= cli_ready;
        if (!sys_rst && up_valid === 1'b1 && up_ready)
            up_got.push_back(up_data);
        n_parse += int'(peer_parse === 1'b1);
        n_event += int'(event_accept === 1'b1);
        n_var += int'(var_rsp_send === 1'b1);
    end
////////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic chk_stream(input logic [7:0] q[$], input logic [7:0] base, input int n);
        chk(q.size(), n);
        for (int i = 0; i < q.size() && i < n; i++)
            chk(q[i], base + i[7:0]);
    endtask
    task automatic chk_tx(input logic [4:0] exp, input logic [4:0] care);
        for (int c = 0; c < 5; c++)
        begin
            @(posedge core_clk);
            tx_code <= c[7:0];
            #1;
            if (care[c])
                chk(tx_allowed, exp[c]);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic wait_for(input logic is_par, input logic [5:0] v);
        int t;
        t = 0;
        #1;
        while ((is_par ? {4'h0, par_state} : disc_state) !== v && t < 30)
        begin
            step(1);
            t++;
        end
        chk(is_par ? {4'h0, par_state} : disc_state, v);
        if (t >= 30)
            summarize();
    endtask
    task automatic cli_burst(input int n, input logic [7:0] base);
        int k;
        int t;
        k = 0;
        t = 0;
        @(posedge core_clk);
        while (k < n && t < 100)
        begin
            cli_valid <= 1'b1;
            cli_data <= base + k[7:0];
            @(posedge core_clk);
            t++;
            if (cli_rdy_n === 1'b1)
                k++;
        end
        cli_valid <= 1'b0;
        cli_data <= ~cli_data;
        chk(k, n);
        if (k != n)
            summarize();
    endtask
    task automatic rx(input int n, input logic [7:0] base);
        logic ok;
        peer.send_rx(n, base, ok);
        chk(ok, 1'b1);
        if (!ok)
            summarize();
    endtask
    task automatic do_reset(input logic act);
        @(posedge core_clk);
        sys_rst <= 1'b1;
        cfg_active <= act;
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
    endtask
    function automatic lop_pkg::lop_info_type mk(input logic [15:0] mp, input logic [15:0] r);
        mk = '0;
        mk.active_mode = 1'b1;
        mk.linkmon_cap = 1'b1;
        mk.max_pdu = mp;
        mk.oui = PEER_OUI;
        mk.revision = r;
    endfunction
////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {errors, tests_run, n_parse, n_event, n_var} = 160'h0;
        {sys_rst, cfg_active, cfg_loopback_cap, cfg_linkmon_cap, cfg_mib_cap} = 5'h10;
        {lb_request, phy_unidir, link_ok, cli_valid, up_ready, stall, cli_rdy_n} = 7'h04;
        {cfg_max_pdu, tx_code, cli_data} = {16'h05DC, 8'h00, 8'h00};
        do_reset(1'b0);
        step(1);
        chk(disc_state, lop_pkg::DISC_FAULT);
        chk(perm, lop_pkg::PERM_FAULT);
        chk(mux_fwd, 1'b0);
        chk(par_state, lop_pkg::PAR_DISC);
        chk(local_info.revision, 16'h0000);
        chk(local_info.oui, OUI);
        chk(eff_pdu, 16'h05DC);
        chk(peer_status, '0);
        cli_burst(2, 8'h10);
        rx(2, 8'h20);
        step(4);
        chk_stream(peer.got, 8'h10, 0);
        chk_stream(up_got, 8'h20, 0);
        @(posedge core_clk);
        link_ok <= 1'b1;
        wait_for(1'b0, lop_pkg::DISC_PASSIVE);
        chk(perm, lop_pkg::PERM_RX);
        chk(local_info.active_mode, 1'b0);
        chk_tx(5'h00, 5'h1F);
        $display("test passive done");
        do_reset(1'b1);
        wait_for(1'b0, lop_pkg::DISC_ACTIVE);
        chk(perm, lop_pkg::PERM_INFO);
        chk(local_info.active_mode, 1'b1);
        chk_tx(5'h01, 5'h1F);
        pk = n_parse;
        peer.send_info(mk(16'h03E8, 16'h0001), 1'b0);
        wait_for(1'b0, lop_pkg::DISC_SLR);
        step(2);
        chk(peer_status, mk(16'h03E8, 16'h0001));
        chk(eff_pdu, 16'h03E8);
        peer.send_info(mk(16'h03E8, 16'h0001), 1'b0);
        step(3);
        chk(n_parse - pk, 1);
        peer.send_info(mk(16'h03E8, 16'h0002), 1'b1);
        wait_for(1'b0, lop_pkg::DISC_SLR_OK);
        peer.send_info(mk(16'h03E8, 16'h0002), 1'b1);
        wait_for(1'b0, lop_pkg::DISC_ANY);
        chk(perm, lop_pkg::PERM_ANY);
        step(2);
        chk(mux_fwd, 1'b1);
        chk(par_state, lop_pkg::PAR_FWD);
        $display("test discovery done");
        cli_burst(3, 8'h30);
        rx(3, 8'h40);
        step(4);
        chk_stream(peer.got, 8'h30, 3);
        chk_stream(up_got, 8'h40, 3);
        peer.got.delete();
        stall <= 1'b1;
        cli_burst(8, 8'h50);
        step(1);
        chk(cli_ready, 1'b0);
        @(posedge core_clk);
        stall <= 1'b0;
        step(12);
        chk_stream(peer.got, 8'h50, 8);
        chk(cli_ready, 1'b1);
        $display("test forwarding done");
        {pe, pv} = {n_event, n_var};
        peer.pulse(1'b1);
        peer.pulse(1'b0);
        lb_request <= 1'b1;
        step(4);
        chk(n_event - pe, 0);
        chk(n_var - pv, 0);
        chk(par_state, lop_pkg::PAR_FWD);
        rv = local_info.revision;
        peer.got.delete();
        @(posedge core_clk);
        {cfg_loopback_cap, cfg_linkmon_cap, cfg_mib_cap} <= 3'h7;
        step(4);
        chk(local_info.revision, rv + 16'h0001);
        peer.pulse(1'b1);
        peer.pulse(1'b0);
        step(3);
        chk(n_event - pe, 1);
        chk(n_var - pv, 1);
        chk_tx(5'h1F, 5'h1F);
        wait_for(1'b1, lop_pkg::PAR_LB);
        rx(3, 8'h60);
        step(4);
        chk_stream(peer.got, 8'h60, 3);
        chk(up_got.size(), 3);
        $display("test capabilities done");
        @(posedge core_clk);
        cfg_max_pdu <= 16'h0384;
        step(3);
        chk(eff_pdu, 16'h0384);
        @(posedge core_clk);
        phy_unidir <= 1'b1;
        link_ok <= 1'b0;
        wait_for(1'b0, lop_pkg::DISC_FAULT);
        @(posedge core_clk);
        link_ok <= 1'b1;
        step(6);
        chk(disc_state, lop_pkg::DISC_FAULT);
        chk(local_info.unidir, 1'b1);
        $display("test unidirectional done");
        summarize();
    end
endmodule
